// ### src/ulm_load_merge.v
/*
  Load datapath for the left, right and unsigned word loads: decode,
  address formation, memory request, byte merge and register write-back.
  Assumes the pipeline supplies base and destination register values at
  issue, and the memory side answers each request with one ack pulse
  carrying the aligned word and a translation or bus error code.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ulm_map.vh"

module ulm_load_merge (
  input wire i_clk_sys,
  input wire i_rstn,
  input wire i_issue,
  input wire [31:0] i_instr,
  input wire [63:0] i_base_value,
  input wire [63:0] i_dest_value,
  input wire i_cpu_byte_order_high_first,
  input wire i_mem_ack,
  input wire [31:0] i_mem_word,
  input wire [1:0] i_mem_err,
  output reg o_busy,
  output reg o_mem_req,
  output reg [63:0] o_mem_addr,
  output reg o_wb_valid,
  output reg [4:0] o_wb_index,
  output reg [63:0] o_wb_data,
  output reg o_exc_valid,
  output reg [2:0] o_exc_code,
  output reg [63:0] o_exc_addr
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [2:0] S_IDLE = 3'h1;
  localparam [2:0] S_ADDR = 3'h2;
  localparam [2:0] S_WAIT = 3'h4;

  reg [2:0] state;
  reg [2:0] next_state;

  // Captured request
  reg op_left;
  reg op_right;
  reg op_unsigned;
  reg [4:0] tgt_index;
  reg [15:0] offset;
  reg [63:0] base_value;
  reg [63:0] dest_value;
  reg order_high_first;
  reg [63:0] eff_addr;

  // Last write-back, kept for the following merge load
  reg fwd_valid;
  reg [4:0] fwd_index;
  reg [63:0] fwd_data;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire [5:0] dec_opc;
  wire dec_left;
  wire dec_right;
  wire dec_unsigned;
  wire [4:0] dec_tgt;
  wire dec_fwd_hit;

  assign dec_opc = i_instr[`ULM_OPC_HI:`ULM_OPC_LO];
  assign dec_left = (dec_opc == `ULM_OPC_LOAD_WORD_LEFT);
  assign dec_right = (dec_opc == `ULM_OPC_LOAD_WORD_RIGHT);
  assign dec_unsigned = (dec_opc == `ULM_OPC_LOAD_WORD_UNSIGNED);
  assign dec_tgt = i_instr[`ULM_TGT_HI:`ULM_TGT_LO];
  // The pipeline register file has not yet seen the last result, so a
  // merge load right behind a load to the same target uses our copy
  assign dec_fwd_hit = fwd_valid & (fwd_index == dec_tgt) &
    (dec_left | dec_right);

  // ----------------------------------------------------------------
  // Address and merge
  // ----------------------------------------------------------------
  wire [63:0] ag_addr;
  wire ag_err;
  wire [63:0] merge_result;

  ulm_addr_gen u_addr_gen (
    .i_base_value(base_value),
    .i_offset(offset),
    .i_need_align(op_unsigned),
    .o_effective_address(ag_addr),
    .o_addr_err(ag_err)
  );

  ulm_lane_merge u_lane_merge (
    .i_op_left(op_left),
    .i_op_right(op_right),
    .i_op_unsigned(op_unsigned),
    .i_cpu_byte_order_high_first(order_high_first),
    .i_addr_lo(eff_addr[1:0]),
    .i_mem_word(i_mem_word),
    .i_dest_value(dest_value),
    .o_result(merge_result)
  );

  // ----------------------------------------------------------------
  // Memory error mapping
  // ----------------------------------------------------------------
  reg [2:0] mem_exc;

  always @* begin
    case (i_mem_err)
      `ULM_MERR_REFILL: mem_exc = `ULM_EXC_REFILL;
      `ULM_MERR_INVALID: mem_exc = `ULM_EXC_INVALID;
      `ULM_MERR_BUS: mem_exc = `ULM_EXC_BUS;
      default: mem_exc = `ULM_EXC_NONE;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always @* begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (i_issue & (dec_left | dec_right | dec_unsigned)) begin
          next_state = S_ADDR;
        end
      end
      S_ADDR: begin
        if (ag_err) begin
          next_state = S_IDLE;
        end else begin
          next_state = S_WAIT;
        end
      end
      S_WAIT: begin
        if (i_mem_ack) begin
          next_state = S_IDLE;
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Step strobes
  // ----------------------------------------------------------------
  wire in_idle;
  wire in_addr;
  wire in_wait;
  wire take_any;
  wire take_load;
  wire take_reserved;
  wire addr_fault;
  wire addr_ok;
  wire wb_take;
  wire err_take;

  assign in_idle = (state == S_IDLE);
  assign in_addr = (state == S_ADDR);
  assign in_wait = (state == S_WAIT);
  // Issues while busy are dropped here, so the pipeline must hold off
  assign take_any = in_idle & i_issue;
  assign take_load = take_any & (dec_left | dec_right | dec_unsigned);
  assign take_reserved = take_any & ~(dec_left | dec_right | dec_unsigned);
  assign addr_fault = in_addr & ag_err;
  assign addr_ok = in_addr & ~ag_err;
  assign wb_take = in_wait & i_mem_ack & (i_mem_err == `ULM_MERR_NONE);
  assign err_take = in_wait & i_mem_ack & (i_mem_err != `ULM_MERR_NONE);

  // ----------------------------------------------------------------
  // State and busy
  // ----------------------------------------------------------------
  // Busy follows the next state so it drops with the last pulse
  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= S_IDLE;
      o_busy <= 1'h0;
    end else begin
      state <= next_state;
      o_busy <= (next_state != S_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // Request capture
  // ----------------------------------------------------------------
  // Values are taken once, so the pipeline may move on at once
  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      op_left <= 1'h0;
      op_right <= 1'h0;
      op_unsigned <= 1'h0;
      tgt_index <= 5'h00;
      offset <= 16'h0000;
      base_value <= 64'h0000000000000000;
      dest_value <= 64'h0000000000000000;
      order_high_first <= 1'h0;
    end else if (take_load) begin
      op_left <= dec_left;
      op_right <= dec_right;
      op_unsigned <= dec_unsigned;
      tgt_index <= dec_tgt;
      offset <= i_instr[`ULM_OFS_HI:`ULM_OFS_LO];
      base_value <= i_base_value;
      dest_value <= dec_fwd_hit ? fwd_data : i_dest_value;
      order_high_first <= i_cpu_byte_order_high_first;
    end
  end

  // ----------------------------------------------------------------
  // Effective address
  // ----------------------------------------------------------------
  // Kept for the merge lanes and for the faulting address report
  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      eff_addr <= 64'h0000000000000000;
    end else if (in_addr) begin
      eff_addr <= ag_addr;
    end
  end

  // ----------------------------------------------------------------
  // Forward copy
  // ----------------------------------------------------------------
  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      fwd_valid <= 1'h0;
      fwd_index <= 5'h00;
      fwd_data <= 64'h0000000000000000;
    end else if (wb_take) begin
      fwd_valid <= 1'h1;
      fwd_index <= tgt_index;
      fwd_data <= merge_result;
    end else if (take_any) begin
      // Any issue ends the back-to-back window
      fwd_valid <= 1'h0;
    end
  end

  // ----------------------------------------------------------------
  // Memory request
  // ----------------------------------------------------------------
  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_mem_req <= 1'h0;
      o_mem_addr <= 64'h0000000000000000;
    end else begin
      o_mem_req <= addr_ok;
      if (addr_ok) begin
        // Memory sees the aligned word holding the address
        o_mem_addr <= {ag_addr[63:2], 2'h0};
      end
    end
  end

  // ----------------------------------------------------------------
  // Write-back
  // ----------------------------------------------------------------
  // Index and data hold until the next write-back
  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_wb_valid <= 1'h0;
      o_wb_index <= 5'h00;
      o_wb_data <= 64'h0000000000000000;
    end else begin
      o_wb_valid <= wb_take;
      if (wb_take) begin
        o_wb_index <= tgt_index;
        o_wb_data <= merge_result;
      end
    end
  end

  // ----------------------------------------------------------------
  // Exception report
  // ----------------------------------------------------------------
  // Causes are exclusive by state; the order only fixes priority
  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_exc_valid <= 1'h0;
      o_exc_code <= `ULM_EXC_NONE;
      o_exc_addr <= 64'h0000000000000000;
    end else begin
      o_exc_valid <= take_reserved | addr_fault | err_take;
      if (take_reserved) begin
        o_exc_code <= `ULM_EXC_RESERVED;
        o_exc_addr <= 64'h0000000000000000;
      end else if (addr_fault) begin
        o_exc_code <= `ULM_EXC_ADDRESS;
        o_exc_addr <= ag_addr;
      end else if (err_take) begin
        o_exc_code <= mem_exc;
        o_exc_addr <= eff_addr;
      end
    end
  end

endmodule // ulm_load_merge
`default_nettype wire

// ### common/ulm_map.vh
/*
  Constants for the unaligned word load merge datapath: opcodes, field
  positions, exception codes and fixed implementation choices.
  Assumes it is included by bare name from the design files.
*/
// Overview of operation
// - Decode load_word_right opcode with base/target/offset fields
// - Effective address is sign-extended offset plus base
// - load_word_right fills low bytes, keeps high bytes
// - Full load_word_right copies new bit 31 upward
// - Partial load_word_right upper half fixed choice
// - Lanes chosen by address low bits and order
// - Back-to-back merge load sees previous load data
// - Left plus right pair yields sign-extended word
// - Merging loads report refill, invalid, bus errors, never address errors
// - load_word_unsigned zero-extends aligned word
// - load_word_unsigned misaligned raises address error
// - load_word_left fills high bytes, keeps low bytes
// - load_word_left always copies new bit 31 upward
`ifndef ULM_MAP_VH
`define ULM_MAP_VH

// ----------------------------------------------------------------
// Instruction fields
// ----------------------------------------------------------------
`define ULM_OPC_HI 31
`define ULM_OPC_LO 26
`define ULM_BASE_HI 25
`define ULM_BASE_LO 21
`define ULM_TGT_HI 20
`define ULM_TGT_LO 16
`define ULM_OFS_HI 15
`define ULM_OFS_LO 0
`define ULM_OPC_LOAD_WORD_LEFT 6'h22
`define ULM_OPC_LOAD_WORD_RIGHT 6'h26
`define ULM_OPC_LOAD_WORD_UNSIGNED 6'h27

// ----------------------------------------------------------------
// Exception codes on o_exc_code
// ----------------------------------------------------------------
`define ULM_EXC_NONE 3'h0
`define ULM_EXC_ADDRESS 3'h1
`define ULM_EXC_REFILL 3'h2
`define ULM_EXC_INVALID 3'h3
`define ULM_EXC_BUS 3'h4
`define ULM_EXC_RESERVED 3'h5

// ----------------------------------------------------------------
// Memory error codes on i_mem_err
// ----------------------------------------------------------------
`define ULM_MERR_NONE 2'h0
`define ULM_MERR_REFILL 2'h1
`define ULM_MERR_INVALID 2'h2
`define ULM_MERR_BUS 2'h3

// ----------------------------------------------------------------
// Implementation choices
// ----------------------------------------------------------------
// Partial right load: 1'h0 keeps bits 63..32, 1'h1 copies old bit 31
`define ULM_PARTIAL_SEXT 1'h0

`endif

// ### src/ulm_addr_gen.v
/*
  Effective address former and alignment checker for the load datapath.
  Assumes base value is the full 64-bit register read by the pipeline.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ulm_map.vh"

module ulm_addr_gen (
  input wire [63:0] i_base_value,
  input wire [15:0] i_offset,
  input wire i_need_align,
  output wire [63:0] o_effective_address,
  output wire o_addr_err
);

  // ----------------------------------------------------------------
  // Address sum
  // ----------------------------------------------------------------
  assign o_effective_address = i_base_value +
    {{48{i_offset[15]}}, i_offset};

  // Merging loads never fault on alignment; only the aligned load does
  assign o_addr_err = i_need_align &
    (o_effective_address[1:0] != 2'h0);

endmodule // ulm_addr_gen
`default_nettype wire

// ### src/ulm_lane_merge.v
/*
  Byte lane merge for left, right and unsigned word loads.
  Assumes the memory word is presented as a 32-bit value, lane 0 lowest.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ulm_map.vh"

module ulm_lane_merge (
  input wire i_op_left,
  input wire i_op_right,
  input wire i_op_unsigned,
  input wire i_cpu_byte_order_high_first,
  input wire [1:0] i_addr_lo,
  input wire [31:0] i_mem_word,
  input wire [63:0] i_dest_value,
  output wire [63:0] o_result
);

  wire [1:0] byte_idx;
  wire [31:0] low_word;
  wire full_right;
  wire [31:0] upper_word;

  // ----------------------------------------------------------------
  // Lane lookup
  // ----------------------------------------------------------------
  assign byte_idx = i_addr_lo ^ {2{i_cpu_byte_order_high_first}};

  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_lane
      wire [31:0] lane_sum;
      wire [1:0] pos_l;
      wire [1:0] pos_r;
      wire take_l;
      wire take_r;
      assign lane_sum = i + {30'h0, byte_idx};
      // Left lanes: top byte_idx+1 lanes from memory lanes 0 upward
      assign pos_l = lane_sum[1:0] + 2'h1;
      assign take_l = (lane_sum >= 32'h00000003);
      // Right lanes: low 4-byte_idx lanes from memory lane byte_idx up
      assign pos_r = lane_sum[1:0];
      assign take_r = (lane_sum <= 32'h00000003);
      assign low_word[8*i+7:8*i] =
        i_op_unsigned ? i_mem_word[8*i+7:8*i] :
        (i_op_left & take_l) ? i_mem_word[8*pos_l +: 8] :
        (i_op_right & take_r) ? i_mem_word[8*pos_r +: 8] :
        i_dest_value[8*i+7:8*i];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Upper half
  // ----------------------------------------------------------------
  assign full_right = i_op_right & (byte_idx == 2'h0);

  assign upper_word =
    i_op_unsigned ? 32'h00000000 :
    (i_op_left | full_right) ? {32{low_word[31]}} :
    `ULM_PARTIAL_SEXT ? {32{i_dest_value[31]}} :
    i_dest_value[63:32];

  // A left/right pair covers all lanes and ends on a sign copy
  assign o_result = {upper_word, low_word};

endmodule // ulm_lane_merge
`default_nettype wire

// ### testbench/ulm_chk_asserts.sv
/* Checker for the load merge block ports.
   Assumes it is bound to every ulm_load_merge instance. */
`timescale 1ns/100ps
`default_nettype none
`include "ulm_map.vh"
module ulm_chk (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_issue,
  input wire logic [31:0] i_instr,
  input wire logic [63:0] i_base_value,
  input wire logic i_cpu_byte_order_high_first,
  input wire logic i_mem_ack,
  input wire logic [31:0] i_mem_word,
  input wire logic [1:0] i_mem_err,
  input wire logic o_busy,
  input wire logic o_mem_req,
  input wire logic [63:0] o_mem_addr,
  input wire logic o_wb_valid,
  input wire logic [4:0] o_wb_index,
  input wire logic [63:0] o_wb_data,
  input wire logic o_exc_valid,
  input wire logic [2:0] o_exc_code,
  input wire logic [63:0] o_exc_addr
);
  // ---
  // Helpers
  // ---
  localparam [5:0] op_l = `ULM_OPC_LOAD_WORD_LEFT;
  localparam [5:0] op_r = `ULM_OPC_LOAD_WORD_RIGHT;
  localparam [5:0] op_u = `ULM_OPC_LOAD_WORD_UNSIGNED;
  wire tk = i_issue && !o_busy;
  wire [5:0] opc = i_instr[31:26];
  wire [63:0] ea = i_base_value + {{48{i_instr[15]}}, i_instr[15:0]};
  reg [63:0] ea_q;
  reg [5:0] op_q;
  reg [4:0] tg_q;
  reg bg_q;
  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      ea_q <= 64'h0;
      op_q <= 6'h0;
      tg_q <= 5'h0;
      bg_q <= 1'b0;
    end else if (tk) begin
      ea_q <= ea;
      op_q <= opc;
      tg_q <= i_instr[20:16];
      bg_q <= i_cpu_byte_order_high_first;
    end
  end
  wire [1:0] b = ea_q[1:0] ^ {2{bg_q}};
  wire ok = i_mem_ack && o_busy && i_mem_err == 2'h0;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  // ---
  // Checks
  // ---
  req_timing_a: assert property (
    tk && (opc == op_l || opc == op_r) |-> ##2 o_mem_req)
    else $error("memory request late");
  req_addr_a: assert property (
    o_mem_req |-> o_mem_addr == {ea_q[63:2], 2'h0})
    else $error("memory address wrong");
  misalign_exc_a: assert property (
    tk && opc == op_u && ea[1:0] != 2'h0 |-> ##2 o_exc_valid
    && o_exc_code == `ULM_EXC_ADDRESS && o_exc_addr == ea_q)
    else $error("no address error");
  misalign_noreq_a: assert property (
    tk && opc == op_u && ea[1:0] != 2'h0 |-> !o_mem_req [*4])
    else $error("request on misaligned load");
  err_map_a: assert property (
    i_mem_ack && o_busy && i_mem_err != 2'h0 |=> o_exc_valid
    && !o_wb_valid && o_exc_code == {1'b0, $past(i_mem_err)} + 3'h1)
    else $error("memory error code wrong");
  wb_done_a: assert property (
    ok |=> o_wb_valid && o_wb_index == tg_q && !o_busy)
    else $error("write-back missing");
  full_word_a: assert property (
    ok && ((op_q == op_r && b == 2'h0) || (op_q == op_l && b == 2'h3))
    |=> o_wb_data[31:0] == $past(i_mem_word))
    else $error("full word not loaded");
  left_sext_a: assert property (
    o_wb_valid && op_q == op_l |-> o_wb_data[63:32] == {32{o_wb_data[31]}})
    else $error("left load not sign-extended");
  right_sext_a: assert property (
    o_wb_valid && op_q == op_r && b == 2'h0
    |-> o_wb_data[63:32] == {32{o_wb_data[31]}})
    else $error("right load not sign-extended");
  uns_zero_a: assert property (
    ok && op_q == op_u |=> o_wb_data == {32'h0, $past(i_mem_word)})
    else $error("unsigned load not zero-extended");
  cover property (o_wb_valid && op_q == op_l);
  cover property (o_wb_valid && op_q == op_r && b != 2'h0);
  cover property (o_exc_valid && o_exc_code == `ULM_EXC_ADDRESS);
  cover property (i_mem_ack && i_mem_err == 2'h3);
endmodule // ulm_chk
bind ulm_load_merge ulm_chk ulm_chk_i (.i_clk_sys(i_clk_sys),
  .i_rstn(i_rstn), .i_issue(i_issue), .i_instr(i_instr),
  .i_base_value(i_base_value), .i_mem_ack(i_mem_ack),
  .i_cpu_byte_order_high_first(i_cpu_byte_order_high_first),
  .i_mem_word(i_mem_word), .i_mem_err(i_mem_err), .o_busy(o_busy),
  .o_mem_req(o_mem_req), .o_mem_addr(o_mem_addr), .o_wb_valid(o_wb_valid),
  .o_wb_index(o_wb_index), .o_wb_data(o_wb_data),
  .o_exc_valid(o_exc_valid), .o_exc_code(o_exc_code),
  .o_exc_addr(o_exc_addr));
`default_nettype wire

// ### testbench/ulm_mem_model.sv
/* Memory and translation model answering word loads.
   Assumes one-cycle requests with the address held until the answer. */
`timescale 1ns/100ps
`default_nettype none
module ulm_mem_model (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_mem_req,
  input wire logic [63:0] i_mem_addr,
  input wire logic [1:0] i_err_sel,
  output logic o_mem_ack,
  output logic [31:0] o_mem_word,
  output logic [1:0] o_mem_err
);
  // ---
  // Answer
  // ---
  logic pend;
  logic [1:0] wait_n;
  // Delay taken from address bits 4:3, so prompt and slow answers both occur
  always @(negedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      pend = 1'b0;
      wait_n = 2'h0;
      o_mem_ack <= 1'b0;
      o_mem_word <= 32'h0;
      o_mem_err <= 2'h0;
    end else begin
      o_mem_ack <= 1'b0;
      // Idle lines keep changing so a stale word can never pass
      o_mem_word <= ~o_mem_word;
      o_mem_err <= o_mem_err + 2'h1;
      if (i_mem_req && !pend) begin
        pend = 1'b1;
        wait_n = i_mem_addr[4:3];
      end
      if (pend && wait_n == 2'h0) begin
        pend = 1'b0;
        o_mem_ack <= 1'b1;
        o_mem_word <= i_mem_addr[33:2] ^ 32'h9E3779B9;
        o_mem_err <= i_err_sel;
      end else if (pend) begin
        wait_n = wait_n - 2'h1;
      end
    end
  end
endmodule // ulm_mem_model
`default_nettype wire

// ### testbench/testbench.sv
/* Self-checking bench for the load merge block with a memory model.
   Assumes a 25 MHz clock and an active-low asynchronous reset. */
`timescale 1ns/100ps
`default_nettype none
`include "ulm_map.vh"
module testbench;
  // ---
  // Setup
  // ---
  localparam [5:0] op_l = `ULM_OPC_LOAD_WORD_LEFT;
  localparam [5:0] op_r = `ULM_OPC_LOAD_WORD_RIGHT;
  localparam [5:0] op_u = `ULM_OPC_LOAD_WORD_UNSIGNED;
  logic clk = 0, rstn = 0, iss = 0, big = 0, fwd_ok = 0;
  logic [31:0] ins = 0, w, r;
  logic [63:0] bv = 0, dv = 0, x, fwd_d, last_wb;
  logic [1:0] es = 0;
  logic [4:0] fwd_i;
  logic [5:0] o;
  logic [15:0] of;
  logic [5:0] opt [3] = '{op_l, op_r, op_u};
  wire ack, busy, req, wbv, exv;
  wire [31:0] mw;
  wire [1:0] me;
  wire [63:0] ma, wbd, exa;
  wire [4:0] wbi;
  wire [2:0] exc;
  int n_errors = 0, num_checks = 0, cyc = 0;
  logic [68:0] q_wb [$];
  logic [66:0] q_ex [$];
  always #20 clk = ~clk;
  ulm_load_merge ulm_load_merge_i (.i_clk_sys(clk), .i_rstn(rstn),
    .i_issue(iss), .i_instr(ins), .i_base_value(bv), .i_dest_value(dv),
    .i_cpu_byte_order_high_first(big), .i_mem_ack(ack), .i_mem_word(mw),
    .i_mem_err(me), .o_busy(busy), .o_mem_req(req), .o_mem_addr(ma),
    .o_wb_valid(wbv), .o_wb_index(wbi), .o_wb_data(wbd),
    .o_exc_valid(exv), .o_exc_code(exc), .o_exc_addr(exa));
  ulm_mem_model ulm_mem_model_i (.i_clk_sys(clk), .i_rstn(rstn),
    .i_mem_req(req), .i_mem_addr(ma), .i_err_sel(es), .o_mem_ack(ack),
    .o_mem_word(mw), .o_mem_err(me));
  // ---
  // Helpers
  // ---
  function logic [7:0] byt(input logic [63:0] n, input logic g);
    logic [31:0] t;
    t = (n[33:2] ^ 32'h9E3779B9) >> {n[1:0] ^ {2{g}}, 3'h0};
    byt = t[7:0];
  endfunction
  function logic [63:0] merge(input logic [5:0] p, input logic [1:0] b,
    input logic [31:0] m, input logic [63:0] d);
    logic [31:0] t;
    t = d[31:0];
    for (int k = 0; k < 4; k++) begin
      if (p == op_l && k >= 3 - b) t[8*k +: 8] = m[8*(k-3+b) +: 8];
      if (p == op_r && k <= 3 - b) t[8*k +: 8] = m[8*(k+b) +: 8];
    end
    if (p == op_u) merge = {32'h0, m};
    else if (p == op_l || b == 2'h0) merge = {{32{t[31]}}, t};
    else merge = {d[63:32], t};
  endfunction
  task chk_wb(input logic [68:0] g, input logic [68:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task chk_ex(input logic [66:0] g, input logic [66:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task finish_test;
    if (n_errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Issue one load, note its expected result, wait until idle again
  task op(input logic [5:0] p, input logic [4:0] tg, input logic [63:0] b,
    input logic [15:0] f, input logic g, input logic [1:0] er);
    logic [63:0] ea, d, di;
    di = {$urandom, $urandom};
    ea = b + {{48{f[15]}}, f};
    d = (fwd_ok && fwd_i == tg && p != op_u) ? fwd_d : di;
    fwd_ok = 0;
    if (p != op_l && p != op_r && p != op_u)
      q_ex.push_back({`ULM_EXC_RESERVED, 64'h0});
    else if (p == op_u && ea[1:0] != 2'h0)
      q_ex.push_back({`ULM_EXC_ADDRESS, ea});
    else if (er != 2'h0)
      q_ex.push_back({{1'b0, er} + 3'h1, ea});
    else begin
      fwd_d = merge(p, ea[1:0] ^ {2{g}}, byt(ea & ~64'h3, 0) |
        {byt(ea | 64'h3, 0), byt(ea & ~64'h3 | 64'h2, 0),
        byt(ea & ~64'h3 | 64'h1, 0), 8'h0}, d);
      fwd_i = tg;
      fwd_ok = 1;
      q_wb.push_back({tg, fwd_d});
    end
    es = er;
    big = g;
    bv = b;
    dv = di;
    ins = {p, 5'h3, tg, f};
    iss = 1;
    @(negedge clk) iss = 0;
    for (int i = 0; i < 40 && (i == 0 || busy); i++) @(negedge clk);
  endtask
  // ---
  // Monitor and run
  // ---
  always @(negedge clk) begin
    if (wbv) begin
      last_wb = wbd;
      chk_wb({wbi, wbd}, q_wb.size() ? q_wb.pop_front() : 'x);
    end
    if (exv) chk_ex({exc, exa}, q_ex.size() ? q_ex.pop_front() : 'x);
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      finish_test;
    end
  end
  initial begin
    void'($urandom(72));
    repeat (3) @(negedge clk);
    rstn = 1;
    // Bench loads the same register in back-to-back slots, so merge loads use the forwarded copy
    for (int g = 0; g < 2; g++)
      for (int a = 0; a < 4; a++)
        foreach (opt[i]) op(opt[i], 5'h1, 64'h1000 + a, 16'hFFF0, g, 0);
    for (int e = 1; e < 4; e++)
      foreach (opt[i]) op(opt[i], 5'h2, 64'h3000, 16'h8, 0, e);
    op(6'h3F, 5'h3, 64'h40, 16'h0, 0, 0);
    for (int g = 0; g < 2; g++)
      for (int a = 1; a < 4; a++) begin
        x = 64'h2000 + a;
        w = g ? {byt(x, 1), byt(x + 1, 1), byt(x + 2, 1), byt(x + 3, 1)}
          : {byt(x + 3, 0), byt(x + 2, 0), byt(x + 1, 0), byt(x, 0)};
        if (a[0]) op(g ? op_l : op_r, 5'h7, x, 16'h0, g, 0);
        op(g ? op_r : op_l, 5'h7, x, 16'h3, g, 0);
        if (!a[0]) op(g ? op_l : op_r, 5'h7, x, 16'h0, g, 0);
        @(negedge clk);
        chk_wb({5'h7, last_wb}, {5'h7, {32{w[31]}}, w});
      end
    repeat (40) begin
      r = $urandom;
      o = opt[r[9:8] % 3];
      of = $urandom;
      if (o == op_u) of[1:0] = 2'h0;
      op(o, {4'h0, r[0]}, {$urandom, $urandom}, of, r[1],
        r[4:2] == 3'h0 ? r[6:5] : 2'h0);
    end
    repeat (4) @(negedge clk);
    chk_ex(67'(q_wb.size() + q_ex.size()), 67'h0);
    finish_test;
  end
endmodule // testbench
`default_nettype wire
